/* File: shared/lane_port_regs.vh */
// Constants of the lane segment packet port controller (attached side).
// Assumes word addressing on the software port, one 32-bit word each.
`ifndef LANE_PORT_REGS_VH
`define LANE_PORT_REGS_VH

`define LANE_COUNT      8
`define ADDR_W          4
// Register word addresses
`define REG_CTRL        4'h0
`define REG_BITMAP      4'h1
`define REG_QUAL        4'h2
`define REG_SEND        4'h3
`define REG_IDLE        4'h4
`define REG_STATUS      4'h5
`define REG_RX_HI       4'h6
`define REG_RX_LO       4'h7
// Control fields
`define CTRL_EN_BIT     0
`define CTRL_LU_LSB     1
`define CTRL_CFG512_BIT 3
`define CTRL_NPRIO_LSB  4
`define CTRL_COLOR_LSB  6
`define CTRL_RESET      32'h0000_0000
// Segment length codes: 0 -> 8, 1 -> 9, 2 -> 10 bytes
`define LU_BASE_LEN     5'h08
// Header bit places (bit 7 is the first transmitted bit)
`define H0_PARITY_BIT   6
`define FILL_BYTE       8'hb5
`define SUBFW_LAST      3'h4
// Status fields
`define ST_PERR_HI      0
`define ST_PERR_LO      1

`endif

/* File: src/lane_port_host.v */
// Attached-side controller for one 8-lane segmented packet port.
// Assumes lane bytes are already 8b/10b coded/decoded outside; one
// interleaved lane byte moves per clk_sys edge on each lane.
//
// Behaviour
// - Each lane interleaves high and low segment bytes, high byte first.
// - Lane bit rate and coding are handled by the external serial macro.
// - A port uses eight lanes; each lane carries one segment per packet.
// - Master segment carries header first; slave segments carry payload only.
// - Segment length is 8, 9 or 10 bytes, same at both ends.
// - All eight segments of a packet start on all lanes together.
// - Attached side processes high channel packet before low channel one.
// - Segments of successive packets follow back to back, no gap.
// - Header is qualifier byte plus one or two further bytes.
// - Reserved header bits pass unchanged; senders drive them zero.
// - Even header parity over all configured header bytes.
// - Idle byte 5 carries side channel, byte 6 extra grants.
// - Data headers carry bitmap in bytes two and three; idle carry grants.
// - A grant is active when its header bit is one.
// - Attached side runs two ingress flywheels, reported in idle headers.
// - Priority flywheel advances each packet cycle, wraps after last priority.
// - Subport flywheel cycles 000 to 100, advancing on priority wrap.
`include "lane_port_regs.vh"

module lane_port_host (
	input  wire        clk_sys,
	input  wire        reset_n,
	input  wire [3:0]  addr,
	input  wire [31:0] wdata,
	input  wire        wr_stb,
	input  wire        rd_stb,
	output reg  [31:0] rdata,
	output reg  [63:0] tx_lane,
	output reg         tx_sof,
	input  wire [63:0] rx_lane,
	input  wire        rx_sof,
	output reg         rx_hi_done,
	output reg         rx_lo_done
);

	reg  [31:0] ctrl_r;
	reg  [15:0] bitmap_r;
	reg  [15:0] qual_r;
	reg  [31:0] idle_r;
	reg         pend_hi_r;
	reg         pend_lo_r;
	reg         data_hi_r;
	reg         data_lo_r;
	reg         running_r;
	reg  [4:0]  idx_r;
	reg  [1:0]  prio_fw_r;
	reg  [2:0]  sub_fw_r;
	reg  [1:0]  perr_r;
	reg  [23:0] rx_hdr_hi_r;
	reg  [23:0] rx_hdr_lo_r;
	reg  [23:0] cap_hi_r;
	reg  [23:0] cap_lo_r;
	reg         lo_pend_r;
	reg         lo_bad_r;
	reg         rx_run_r;
	reg  [4:0]  ridx_r;
	reg  [64:0] s1_r;
	reg  [64:0] s2_r;
	reg  [64:0] s3_r;
	reg  [64:0] filt_r;
	reg  [63:0] tx_nxt;

	wire        enable  = ctrl_r[`CTRL_EN_BIT];
	wire        cfg512  = ctrl_r[`CTRL_CFG512_BIT];
	wire [1:0]  nprio   = ctrl_r[`CTRL_NPRIO_LSB+1:`CTRL_NPRIO_LSB];
	wire [1:0]  color   = ctrl_r[`CTRL_COLOR_LSB+1:`CTRL_COLOR_LSB];
	wire [4:0]  lu_len  = `LU_BASE_LEN
		+ {3'h0, ctrl_r[`CTRL_LU_LSB+1:`CTRL_LU_LSB]};
	wire [4:0]  last_idx = {lu_len[3:0], 1'b0} - 5'h01;
	wire        latch   = enable & (~running_r | (idx_r == last_idx));
	wire        ch_lo   = idx_r[0];
	wire [3:0]  byte_no = idx_r[4:1];
	wire        sof_f   = filt_r[64];

	// Even header parity: parity bit equals XOR of every other header bit
	function par_of;
		input [7:0] h0;
		input [7:0] h1;
		input [7:0] h2;
		input       three;
		begin
			par_of = ^{h0[7], h0[5:0], h1, (three ? h2 : 8'h00)};
		end
	endfunction

	// Qualifier byte with the parity bit put in place
	function [7:0] with_par;
		input [7:0] h0;
		input [7:0] h1;
		input [7:0] h2;
		input       three;
		begin
			with_par = h0;
			with_par[`H0_PARITY_BIT] = par_of(h0, h1, h2, three);
		end
	endfunction

	// Idle qualifier: flywheel status, zero protection, colour
	function [7:0] idle_h0;
		input       lo;
		input [2:0] sub;
		input [1:0] pri;
		input [1:0] col;
		begin
			if (lo)
				idle_h0 = {1'b0, 1'b0, 2'b00, col, pri};
			else
				idle_h0 = {sub[2], 1'b0, 2'b00, col, sub[1:0]};
		end
	endfunction

	// Idle grant bytes travel in header bytes two and three
	wire [7:0] ig_h1 = idle_r[23:16];
	wire [7:0] ig_h2 = idle_r[31:24];
	wire [7:0] idle_q = idle_h0(ch_lo, sub_fw_r, prio_fw_r, color);
	wire [7:0] data_q = ch_lo ? qual_r[15:8] : qual_r[7:0];
	wire       is_data = ch_lo ? data_lo_r : data_hi_r;

	// Software register writes; send requests set over the consuming latch
	always @(posedge clk_sys or negedge reset_n)
	begin
		if (!reset_n)
		begin
			ctrl_r    <= `CTRL_RESET;
			bitmap_r  <= 16'h0000;
			qual_r    <= 16'h0000;
			idle_r    <= 32'h0000_0000;
			pend_hi_r <= 1'b0;
			pend_lo_r <= 1'b0;
		end
		else
		begin
			if (wr_stb && addr == `REG_CTRL)
				ctrl_r <= wdata;
			if (wr_stb && addr == `REG_BITMAP)
				bitmap_r <= wdata[15:0];
			if (wr_stb && addr == `REG_QUAL)
				qual_r <= wdata[15:0];
			if (wr_stb && addr == `REG_IDLE)
				idle_r <= wdata;
			pend_hi_r <= (wr_stb && addr == `REG_SEND && wdata[0])
				| (pend_hi_r & ~latch);
			pend_lo_r <= (wr_stb && addr == `REG_SEND && wdata[1])
				| (pend_lo_r & ~latch);
		end
	end

	// Packet cycle sequencer and ingress flywheels
	always @(posedge clk_sys or negedge reset_n)
	begin
		if (!reset_n)
		begin
			running_r <= 1'b0;
			idx_r     <= 5'h00;
			data_hi_r <= 1'b0;
			data_lo_r <= 1'b0;
			prio_fw_r <= 2'b00;
			sub_fw_r  <= 3'b000;
		end
		else if (!enable)
		begin
			running_r <= 1'b0;
			idx_r     <= 5'h00;
		end
		else if (latch)
		begin
			running_r <= 1'b1;
			idx_r     <= 5'h00;
			data_hi_r <= pend_hi_r;
			data_lo_r <= pend_lo_r;
			if (running_r)
			begin
				if (prio_fw_r >= nprio)
				begin
					prio_fw_r <= 2'b00;
					if (sub_fw_r >= `SUBFW_LAST)
						sub_fw_r <= 3'b000;
					else
						sub_fw_r <= sub_fw_r + 3'b001;
				end
				else
					prio_fw_r <= prio_fw_r + 2'b01;
			end
		end
		else
			idx_r <= idx_r + 5'h01;
	end

	// Byte for each lane in the current interleave slot
	always @*
	begin : lane_bytes
		integer l;
		reg [7:0] b;
		tx_nxt = 64'h0;
		b = 8'h00;
		for (l = 0; l < `LANE_COUNT; l = l + 1)
		begin
			if (is_data)
			begin
				if (l == 0 && byte_no == 4'h0)
					b = with_par(data_q, bitmap_r[7:0], bitmap_r[15:8],
						cfg512);
				else if (l == 0 && byte_no == 4'h1)
					b = bitmap_r[7:0];
				else if (l == 0 && byte_no == 4'h2 && cfg512)
					b = bitmap_r[15:8];
				else
					b = {l[2:0], ch_lo, byte_no};
			end
			else if (l == 0)
			begin
				case (byte_no)
				4'h0: b = with_par(idle_q, ig_h1, ig_h2, cfg512);
				4'h1: b = ig_h1;
				4'h2: b = ig_h2;
				4'h5: b = {idle_r[3:0], idle_r[3:0]};
				4'h6: b = idle_r[15:8];
				default: b = `FILL_BYTE;
				endcase
			end
			else
				b = `FILL_BYTE;
			tx_nxt[8*l +: 8] = b;
		end
	end

	// Registered lane outputs; start marker common to all lanes
	// external coder serializes bytes
	always @(posedge clk_sys or negedge reset_n)
	begin
		if (!reset_n)
		begin
			tx_lane <= 64'h0;
			tx_sof  <= 1'b0;
		end
		else
		begin
			tx_lane <= running_r ? tx_nxt : 64'h0;
			tx_sof  <= running_r & (idx_r == 5'h00);
		end
	end

	// Lane pins pass four flops; bytes change every cycle, so an agreement
	// filter would drop them and the one-cycle start marker: stage only
	genvar g;
	generate
		for (g = 0; g <= 64; g = g + 1)
		begin : rx_sync
			wire pin = (g == 64) ? rx_sof : rx_lane[g];
			always @(posedge clk_sys or negedge reset_n)
			begin
				if (!reset_n)
				begin
					s1_r[g]   <= 1'b0;
					s2_r[g]   <= 1'b0;
					s3_r[g]   <= 1'b0;
					filt_r[g] <= 1'b0;
				end
				else
				begin
					s1_r[g] <= pin;
					s2_r[g] <= s1_r[g];
					s3_r[g] <= s2_r[g];
					filt_r[g] <= s3_r[g];
				end
			end
		end
	endgenerate

	wire [7:0] rx_b0   = filt_r[7:0];
	wire [3:0] rbyte   = ridx_r[4:1];
	wire       rlast   = rx_run_r && (ridx_r == last_idx);
	wire [23:0] hi_now = cap_hi_r;
	wire [23:0] lo_now = (rbyte == 4'h0) ? cap_lo_r
		: {cap_lo_r[23:8], cap_lo_r[7:0]};
	wire       bad_hi = par_of(hi_now[7:0], hi_now[15:8], hi_now[23:16],
		cfg512) != hi_now[`H0_PARITY_BIT];
	wire       bad_lo = par_of(lo_now[7:0], lo_now[15:8], lo_now[23:16],
		cfg512) != lo_now[`H0_PARITY_BIT];
	wire       clr_w  = wr_stb && addr == `REG_STATUS;

	// Egress receive: gather master lane header, check, hand high over first
	always @(posedge clk_sys or negedge reset_n)
	begin
		if (!reset_n)
		begin
			rx_run_r    <= 1'b0;
			ridx_r      <= 5'h00;
			cap_hi_r    <= 24'h0;
			cap_lo_r    <= 24'h0;
			rx_hdr_hi_r <= 24'h0;
			rx_hdr_lo_r <= 24'h0;
			lo_pend_r   <= 1'b0;
			lo_bad_r    <= 1'b0;
			rx_hi_done  <= 1'b0;
			rx_lo_done  <= 1'b0;
			perr_r      <= 2'b00;
		end
		else
		begin
			if (sof_f && (!rx_run_r || rlast))
			begin
				rx_run_r <= enable;
				ridx_r   <= 5'h01;
				cap_hi_r <= {16'h0, rx_b0};
			end
			// Disable drops a half-received packet so a restart aligns
			else if (!enable)
				rx_run_r <= 1'b0;
			else if (rx_run_r)
			begin
				ridx_r <= rlast ? 5'h00 : ridx_r + 5'h01;
				rx_run_r <= ~rlast;
				if (rbyte < 4'h3)
				begin
					if (ridx_r[0])
						cap_lo_r[8*rbyte[1:0] +: 8] <= rx_b0;
					else
						cap_hi_r[8*rbyte[1:0] +: 8] <= rx_b0;
				end
			end
			// high channel packet handed over first
			rx_hi_done <= rlast;
			if (rlast)
			begin
				rx_hdr_hi_r <= hi_now;
				lo_pend_r   <= 1'b1;
				lo_bad_r    <= bad_lo;
			end
			else
				lo_pend_r <= 1'b0;
			rx_lo_done <= lo_pend_r;
			if (lo_pend_r)
				rx_hdr_lo_r <= cap_lo_r;
			// Parity error flags: a new error wins over a clear
			perr_r[`ST_PERR_HI] <= (rlast & bad_hi)
				| (perr_r[`ST_PERR_HI] & ~(clr_w & wdata[`ST_PERR_HI]));
			perr_r[`ST_PERR_LO] <= (lo_pend_r & lo_bad_r)
				| (perr_r[`ST_PERR_LO] & ~(clr_w & wdata[`ST_PERR_LO]));
		end
	end

	// Read data appears the cycle after the read strobe, zero otherwise
	always @(posedge clk_sys or negedge reset_n)
	begin
		if (!reset_n)
			rdata <= 32'h0;
		else if (!rd_stb)
			rdata <= 32'h0;
		else
		begin
			case (addr)
			`REG_CTRL:   rdata <= ctrl_r;
			`REG_BITMAP: rdata <= {16'h0, bitmap_r};
			`REG_QUAL:   rdata <= {16'h0, qual_r};
			`REG_SEND:   rdata <= {30'h0, pend_lo_r, pend_hi_r};
			`REG_IDLE:   rdata <= idle_r;
			`REG_STATUS: rdata <= {25'h0, prio_fw_r, sub_fw_r, perr_r};
			`REG_RX_HI:  rdata <= {8'h0, rx_hdr_hi_r};
			`REG_RX_LO:  rdata <= {8'h0, rx_hdr_lo_r};
			default:     rdata <= 32'h0;
			endcase
		end
	end

endmodule // lane_port_host

/* File: verification/lane_port_host_asserts.sv */
// Port assertions for the lane port host controller.
// Bound to lane_port_host; one clock, async active-low reset.
`include "lane_port_regs.vh"
module lane_port_host_asserts (
	input wire        clk_sys,
	input wire        reset_n,
	input wire [3:0]  addr,
	input wire [31:0] wdata,
	input wire        wr_stb,
	input wire        rd_stb,
	input wire [31:0] rdata,
	input wire [63:0] tx_lane,
	input wire        tx_sof,
	input wire        rx_hi_done,
	input wire        rx_lo_done
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [3:0] ctl_r;
	logic       seen_r;
	logic [4:0] gap_r;
	wire        ctl_wr = wr_stb && addr == `REG_CTRL;
	wire [7:0]  b = tx_lane[7:0];
	// Shadow control word; a rewrite voids the gap count
	always @(posedge clk_sys or negedge reset_n)
	begin
		if (!reset_n)
		begin
			ctl_r  <= 4'h0;
			seen_r <= 1'b0;
			gap_r  <= 5'h00;
		end
		else
		begin
			if (ctl_wr)
				ctl_r <= wdata[3:0];
			seen_r <= !ctl_wr && (tx_sof || seen_r);
			gap_r  <= tx_sof ? 5'h00 : gap_r + 5'h01;
		end
	end
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!reset_n);
	// Parity bit 6 equals the xor of all other header bits
	function automatic logic ok(input logic [7:0] q, input logic [15:0] r);
		ok = q[6] == ^{q[7], q[5:0], r};
	endfunction
	// Header bytes sit two slots apart on lane 0, high first
	sequence s_hdr2;
		tx_sof && ctl_r[0] && !ctl_r[3] ##1 ctl_r[0] [*3];
	endsequence
	sequence s_hdr3;
		tx_sof && ctl_r[0] && ctl_r[3] ##1 ctl_r[0] [*5];
	endsequence
	chk_read_quiet:
		assert property (!rd_stb |=> rdata == 32'h0)
		else $error("rdata not zero outside a read");
	chk_unmapped_zero:
		assert property (rd_stb && addr[3] |=> rdata == 32'h0)
		else $error("unmapped read not zero");
	chk_segment_gap:
		assert property (tx_sof && seen_r |->
			gap_r == 5'd15 + {2'b00, ctl_r[2:1], 1'b0})
		else $error("packet start spacing wrong");
	chk_start_lead:
		assert property (ctl_wr && wdata[0] && !ctl_r[0] |-> ##[1:3] tx_sof)
		else $error("no packet start after enable");
	chk_stop_quiet:
		assert property (!ctl_r[0] [*3] |-> tx_lane == 64'h0 && !tx_sof)
		else $error("lanes active while disabled");
	chk_hdr_parity2:
		assert property (s_hdr2 |-> ok($past(b, 3), {8'h00, $past(b, 1)})
			&& ok($past(b, 2), {8'h00, b}))
		else $error("two-byte header parity wrong");
	chk_hdr_parity3:
		assert property (s_hdr3 |-> ok($past(b, 5), {$past(b, 3), $past(b, 1)})
			&& ok($past(b, 4), {$past(b, 2), b}))
		else $error("three-byte header parity wrong");
	chk_hi_then_lo:
		assert property (rx_hi_done |=> rx_lo_done)
		else $error("low header not done after high");
	chk_lo_follows:
		assert property (rx_lo_done |-> $past(rx_hi_done))
		else $error("low header done without high");
endmodule // lane_port_host_asserts

bind lane_port_host lane_port_host_asserts chk (.clk_sys, .reset_n, .addr,
	.wdata, .wr_stb, .rd_stb, .rdata, .tx_lane, .tx_sof, .rx_hi_done,
	.rx_lo_done);

/* File: verification/lane_dev_model.sv */
// Switch-side model: egress idle packets on eight lanes.
// Assumes len and three match the host's control word.
module lane_dev_model (
	input  wire logic        clk_sys,
	input  wire logic        reset_n,
	input  wire logic        run,
	input  wire logic        bad,
	input  wire logic        three,
	input  wire logic [3:0]  len,
	output logic      [63:0] rx_lane,
	output logic             rx_sof
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [4:0] slot_r;
	logic [7:0] b0;
	// even parity in bit 6, reserved bits zero
	function automatic logic [7:0] qual(input logic [7:0] q, h, input logic f);
		qual = q | {1'b0, ^{q, h} ^ f, 6'h00};
	endfunction
	// lane 0 headers, high slot first; fill after
	always_comb
	begin
		case (slot_r)
			5'd0: b0 = qual(8'h11, 8'h5b, bad ^ three);
			5'd1: b0 = qual(8'h22, 8'ha5, three);
			5'd2: b0 = 8'h5b;
			5'd3: b0 = 8'ha5;
			default: b0 = 8'hb5;
		endcase
	end
	// lanes start together; released lanes toggle
	always @(posedge clk_sys or negedge reset_n)
	begin
		if (!reset_n)
		begin
			slot_r  <= 5'h00;
			rx_sof  <= 1'b0;
			rx_lane <= 64'h0;
		end
		else if (!run)
		begin
			slot_r  <= 5'h00;
			rx_sof  <= 1'b0;
			rx_lane <= ~rx_lane;
		end
		else
		begin
			rx_sof  <= slot_r == 5'h00;
			rx_lane <= {{7{8'hb5}}, b0};
			slot_r  <= (slot_r == {len, 1'b0} - 5'h01) ? 5'h00 : slot_r + 5'h01;
		end
	end
endmodule // lane_dev_model

/* File: verification/lane_port_host_tb.sv */
// Bench for lane_port_host against the switch-side lane model.
// Assumes 50 MHz clk_sys and the register map of the port header.
`include "lane_port_regs.vh"
module lane_port_host_tb;
	timeunit 1ns;
	timeprecision 1ns;
	typedef struct packed {logic w; logic [3:0] a; logic [31:0] d;} row_t;
	logic        clk_sys = 1'b0, reset_n = 1'b0, run = 1'b0, bad = 1'b0;
	logic        wr_stb = 1'b0, rd_stb = 1'b0, three = 1'b0;
	logic [3:0]  addr = 4'h0, len = 4'h8;
	logic [31:0] wdata = 32'h0, rdata, v;
	logic [63:0] tx_lane, rx_lane;
	logic        tx_sof, rx_sof, rx_hi_done, rx_lo_done;
	logic [1:0]  p;
	logic [2:0]  s;
	int          fail_count = 0, n_compared = 0, cyc = 0;
	row_t        rows[8] = '{{1'b1, `REG_CTRL, 32'h30},
		{1'b0, `REG_CTRL, 32'h30}, {1'b1, `REG_BITMAP, 32'h1234},
		{1'b0, `REG_BITMAP, 32'h1234}, {1'b1, 4'h9, 32'hffff},
		{1'b0, 4'h9, 32'h0}, {1'b0, `REG_STATUS, 32'h0},
		{1'b0, `REG_RX_HI, 32'h0}};
	lane_port_host uut (.clk_sys, .reset_n, .addr, .wdata, .wr_stb, .rd_stb,
		.rdata, .tx_lane, .tx_sof, .rx_lane, .rx_sof, .rx_hi_done, .rx_lo_done);
	lane_dev_model dev (.clk_sys, .reset_n, .run, .bad, .three, .len, .rx_lane,
		.rx_sof);
	// Clock, and a watchdog well above the roughly 770 cycles needed
	always #10 clk_sys = ~clk_sys;
	always @(posedge clk_sys)
	begin
		cyc <= cyc + 1;
		if (cyc == 5000)
		begin
			fail_count++;
			tally_and_finish();
		end
	end
	task automatic cmp(input string nm, input logic [31:0] e, g);
		n_compared++;
		if (g !== e)
		begin
			fail_count++;
			$display("Error %s expected %h seen %h", nm, e, g);
		end
	endtask
	// Strobe then an idle edge, so back-to-back calls never clash
	task automatic wr(input logic [3:0] a, input logic [31:0] d);
		addr <= a;
		wdata <= d;
		wr_stb <= 1'b1;
		@(posedge clk_sys);
		wr_stb <= 1'b0;
		@(posedge clk_sys);
	endtask
	task automatic rd(input logic [3:0] a);
		addr <= a;
		rd_stb <= 1'b1;
		@(posedge clk_sys);
		rd_stb <= 1'b0;
		@(posedge clk_sys);
		v = rdata;
	endtask
	task automatic wait_ev(input logic hi);
		int n;
		n = 0;
		do
		begin
			@(posedge clk_sys);
			n++;
		end
		while ((hi ? rx_hi_done : tx_sof) !== 1'b1 && n < 100);
		cmp("event wait", 32'h0, n >= 100);
	endtask
	task automatic tally_and_finish;
		if (fail_count == 0 && n_compared > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask
	initial
	begin
		repeat (3) @(posedge clk_sys);
		reset_n <= 1'b1;
		@(posedge clk_sys);
		foreach (rows[i])
		begin
			if (rows[i].w)
				wr(rows[i].a, rows[i].d);
			else
			begin
				rd(rows[i].a);
				cmp("register", rows[i].d, v);
			end
		end
		run <= 1'b1;
		wr(`REG_CTRL, 32'h31);
		wait_ev(1'b1);
		rd(`REG_RX_HI);
		cmp("rx high header", 32'h5b51, v[15:0]);
		rd(`REG_RX_LO);
		cmp("rx low header", 32'ha522, v[15:0]);
		// Reads sixteen cycles apart see exactly one flywheel step
		rd(`REG_STATUS);
		{p, s} = v[6:2];
		repeat (24)
		begin
			repeat (14) @(posedge clk_sys);
			if (p == 2'd3)
				s = (s == `SUBFW_LAST) ? 3'h0 : s + 3'h1;
			p = (p == 2'd3) ? 2'd0 : p + 2'd1;
			rd(`REG_STATUS);
			cmp("flywheel", {p, s}, v[6:2]);
		end
		bad <= 1'b1;
		repeat (40) @(posedge clk_sys);
		bad <= 1'b0;
		repeat (40) @(posedge clk_sys);
		rd(`REG_STATUS);
		cmp("parity flags", 32'h1, v[1:0]);
		wr(`REG_STATUS, 32'h3);
		rd(`REG_STATUS);
		cmp("parity clear", 32'h0, v[1:0]);
		wait_ev(1'b0);
		wr(`REG_SEND, 32'h1);
		wait_ev(1'b0);
		repeat (2) @(posedge clk_sys);
		cmp("bitmap byte", 32'h34, tx_lane[7:0]);
		@(posedge clk_sys);
		cmp("idle grant byte", 32'h0, tx_lane[7:0]);
		// Nine-byte segments, then ten with a three-byte header
		for (int c = 1; c < 3; c++)
		begin
			run <= 1'b0;
			wr(`REG_CTRL, 32'h30);
			len <= c == 1 ? 4'h9 : 4'ha;
			three <= c == 2;
			run <= 1'b1;
			wr(`REG_CTRL, c == 1 ? 32'h33 : 32'h3d);
			repeat (100) @(posedge clk_sys);
			rd(`REG_STATUS);
			cmp("segment length", 32'h0, v[1:0]);
		end
		reset_n <= 1'b0;
		@(posedge clk_sys);
		reset_n <= 1'b1;
		@(posedge clk_sys);
		rd(`REG_CTRL);
		cmp("control after reset", 32'h0, v);
		tally_and_finish();
	end
endmodule // lane_port_host_tb
